// >>> board_ctl_pkg.sv
// Constants and carrier types for the board control register bank
package board_ctl_pkg;

  // Bus and bank geometry
  localparam int          DATA_W      = 32;
  localparam int          REG_COUNT   = 8;
  localparam int          IDX_W       = 3;
  localparam int          FIELD_W     = 8;

  // Register byte offsets and their word indexes
  localparam logic [7:0]  LED_CTL_OFS  = 8'h00;
  localparam logic [7:0]  PORT_CTL_OFS = 8'h04;
  localparam logic [2:0]  LED_CTL_IDX  = LED_CTL_OFS[4:2];
  localparam logic [2:0]  PORT_CTL_IDX = PORT_CTL_OFS[4:2];

  // Bit numbers as seen by software (bit 0 is the data MSB)
  localparam int          CFG_SOURCE_BIT   = 0;
  localparam int          BOOT_FLASH_BIT   = 1;
  localparam int          CELL_EN_BIT      = 2;
  localparam int          CELL_RST_BIT     = 3;
  localparam int          ETH1_IEN_BIT     = 4;
  localparam int          ETH1_RST_BIT     = 5;
  localparam int          SER1_EN_BIT      = 6;
  localparam int          SER2_EN_BIT      = 7;
  localparam int          LED_ONE_BIT      = 6;
  localparam int          LED_TWO_BIT      = 7;

  // Data lane that carries bits 0 to 7
  localparam int          FIELD_MSB_POS = 31;
  localparam int          FIELD_LSB_POS = 24;

  // Reset values and writable masks, indexed by bit number
  localparam logic [7:0]  LED_CTL_RST   = 8'h00;
  localparam logic [7:0]  LED_CTL_WMASK = 8'hff;
  localparam logic [7:0]  PORT_CTL_RST  = 8'hfc;
  localparam logic [7:0]  PORT_CTL_WMASK = 8'hfc;

  // Strap level held on the Ethernet PHY management disable pin
  localparam logic        MGMT_DIS_LEVEL = 1'b0;

  // Level that asserts a serial modem output
  localparam logic        MODEM_ASSERTED = 1'b1;

  // Module enables, active low, also routed to the expansion connectors
  typedef struct packed {
    logic cell_phy_enable_n;
    logic serial1_xcvr_enable_n;
    logic serial2_xcvr_enable_n;
  } module_enables_t;

  // Serial port handshake outputs toward the line
  typedef struct packed {
    logic carrier_detect;
    logic data_set_ready;
    logic clear_to_send;
  } modem_out_t;

  // USB pull-up and supply controls
  typedef struct packed {
    logic dplus_pullup_en;
    logic dminus_pullup_en;
    logic vbus_connect;
  } usb_ctl_t;

endpackage

// >>> ctl_field.sv
// Writable control field with per-bit write mask and reset value
`timescale 1ns/1ns
module ctl_field #(
  parameter int                 WIDTH   = 8,
  parameter logic [WIDTH-1:0]   RST_VAL = '0,
  parameter logic [WIDTH-1:0]   WMASK   = '1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] field_q;
  logic [WIDTH-1:0] field_d;

  // Masked bits keep their value on a write
  assign field_d = (wr_data & WMASK) | (field_q & ~WMASK);

  // Field storage, defaults on power-on reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      field_q <= RST_VAL;
    else if (ce && wr_en)
      field_q <= field_d;
  end

  assign q = field_q;

endmodule // ctl_field

// >>> board_ctl_regs.sv
// Board control and status register bank on a chip-select region
`timescale 1ns/1ns

module board_ctl_regs
  import board_ctl_pkg::*;
(
  input  wire logic                           CLK,
  input  wire logic                           RST,
  input  wire logic                           CE,
  input  wire logic                           CS_N,
  input  wire logic [board_ctl_pkg::IDX_W-1:0] ADDR,
  input  wire logic                           WE_N,
  input  wire logic [board_ctl_pkg::DATA_W-1:0] DATA_IN,
  output logic      [board_ctl_pkg::DATA_W-1:0] DATA_OUT,
  output logic                                DATA_OE_N,
  input  wire logic                           HARD_RESET_N,
  input  wire logic                           CFG_SOURCE_JUMPER,
  input  wire logic                           BOOT_SELECT_FLASH,
  input  wire logic                           USB_SPEED_SELECT,
  input  wire logic                           USB_POWER_ENABLE_N,
  input  wire logic                           SER1_TERMINAL_READY,
  input  wire logic                           SER2_TERMINAL_READY,
  output logic                                USER_LED_ONE,
  output logic                                USER_LED_TWO,
  output board_ctl_pkg::module_enables_t      MODULE_ENABLES_N,
  output board_ctl_pkg::module_enables_t      EXP_ENABLES_N,
  output logic                                CELL_PHY_RESET_N,
  output logic                                ETH1_INITIAL_ENABLE_N,
  output logic                                ETH1_PHY_RESET_N,
  output logic                                MGMT_DISABLE_STRAP,
  output board_ctl_pkg::usb_ctl_t             USB_CTL,
  output board_ctl_pkg::modem_out_t           SER1_MODEM,
  output board_ctl_pkg::modem_out_t           SER2_MODEM,
  output logic      [1:0]                     TERMINAL_READY
);

  import board_ctl_pkg::*;

  // ------------------------------------------------------------
  // Bus request decode
  // ------------------------------------------------------------

  // Access qualifiers for the current cycle
  logic                 bank_sel;
  logic                 wr_access;
  logic                 rd_access;

  // Register select from the three decoded address lines
  logic                 hit_led_ctl;
  logic                 hit_port_ctl;

  // Field lane of the write data, reindexed by bit number
  logic [FIELD_W-1:0]   wr_field;

  // A cycle with chip select low and the clock enabled is one access
  assign bank_sel  = ~CS_N & CE;
  assign wr_access = bank_sel & ~WE_N;
  assign rd_access = bank_sel & WE_N;

  // All three address lines are compared, so the bank does not mirror
  assign hit_led_ctl  = (ADDR == LED_CTL_IDX);
  assign hit_port_ctl = (ADDR == PORT_CTL_IDX);

  // Bit n of a field is carried on data line 31 minus n
  genvar gi;
  generate
    for (gi = 0; gi < FIELD_W; gi++)
    begin : g_wr_lane
      assign wr_field[gi] = DATA_IN[FIELD_MSB_POS - gi];
    end
  endgenerate

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------

  // Write strobes per register
  logic                 led_ctl_we;
  logic                 port_ctl_we;

  // Stored control fields, indexed by bit number
  logic [FIELD_W-1:0]   led_ctl;
  logic [FIELD_W-1:0]   port_ctl;

  // Writes to indexes without storage fall away here
  assign led_ctl_we  = wr_access & hit_led_ctl;
  assign port_ctl_we = wr_access & hit_port_ctl;

  // LED register: every low bit writable, all zero at power-on
  ctl_field #(
    .WIDTH   (FIELD_W),
    .RST_VAL (LED_CTL_RST),
    .WMASK   (LED_CTL_WMASK)
  ) u_led_ctl (
    .clk     (CLK),
    .rst     (RST),
    .ce      (CE),
    .wr_en   (led_ctl_we),
    .wr_data (wr_field),
    .q       (led_ctl)
  );

  // Port register: jumper bits are masked off, the rest default high
  ctl_field #(
    .WIDTH   (FIELD_W),
    .RST_VAL (PORT_CTL_RST),
    .WMASK   (PORT_CTL_WMASK)
  ) u_port_ctl (
    .clk     (CLK),
    .rst     (RST),
    .ce      (CE),
    .wr_en   (port_ctl_we),
    .wr_data (wr_field),
    .q       (port_ctl)
  );

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------

  // Jumper levels shown in the read-only bits of the port register
  logic [FIELD_W-1:0]   port_view;

  // Field chosen by the address, by bit number
  logic [FIELD_W-1:0]   rd_field;

  // Full data word as it goes onto the bus
  logic [DATA_W-1:0]    rd_word;

  // Registered read data and driver enable
  logic [DATA_W-1:0]    rd_data_q;
  logic [DATA_W-1:0]    rd_data_d;
  logic                 oe_n_q;
  logic                 oe_n_d;

  // Jumpers replace the stored bits 0 and 1 on reads
  always_comb
  begin
    port_view                 = port_ctl;
    port_view[CFG_SOURCE_BIT] = CFG_SOURCE_JUMPER;
    port_view[BOOT_FLASH_BIT] = BOOT_SELECT_FLASH;
  end

  // Indexes 2 to 7 hold nothing and read as zero
  assign rd_field = hit_led_ctl  ? led_ctl   :
                    hit_port_ctl ? port_view :
                    '0;

  // Place bit n on line 31 minus n, lines 23 to 0 stay zero
  generate
    for (gi = 0; gi < DATA_W; gi++)
    begin : g_rd_lane
      if (gi >= FIELD_LSB_POS)
      begin : g_field
        assign rd_word[gi] = rd_field[FIELD_MSB_POS - gi];
      end
      else
      begin : g_empty
        assign rd_word[gi] = 1'b0;
      end
    end
  endgenerate

  // Data captured on a read, held otherwise
  assign rd_data_d = rd_access ? rd_word : rd_data_q;

  // Drive the bus in the cycle after a read was seen
  assign oe_n_d = ~rd_access;

  // Read data and driver enable registers
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rd_data_q <= '0;
      oe_n_q    <= 1'b1;
    end
    else if (CE)
    begin
      rd_data_q <= rd_data_d;
      oe_n_q    <= oe_n_d;
    end
  end

  assign DATA_OUT  = rd_data_q;
  assign DATA_OE_N = oe_n_q;

  // ------------------------------------------------------------
  // Board control outputs
  // ------------------------------------------------------------

  // User LEDs follow their bits directly
  assign USER_LED_ONE = led_ctl[LED_ONE_BIT];
  assign USER_LED_TWO = led_ctl[LED_TWO_BIT];

  // Module enables from the port register
  module_enables_t enables_n;

  // High puts the module in standby and frees its pins off board
  always_comb
  begin
    enables_n.cell_phy_enable_n     = port_ctl[CELL_EN_BIT];
    enables_n.serial1_xcvr_enable_n = port_ctl[SER1_EN_BIT];
    enables_n.serial2_xcvr_enable_n = port_ctl[SER2_EN_BIT];
  end

  // Same enables reach the board modules and the expansion connectors
  assign MODULE_ENABLES_N = enables_n;
  assign EXP_ENABLES_N    = enables_n;

  // PHY resets are held while either the bit or hard reset is low
  assign CELL_PHY_RESET_N = port_ctl[CELL_RST_BIT] & HARD_RESET_N;
  assign ETH1_PHY_RESET_N = port_ctl[ETH1_RST_BIT] & HARD_RESET_N;

  // Strap level; the PHY only samples it as its reset is released
  assign ETH1_INITIAL_ENABLE_N = port_ctl[ETH1_IEN_BIT];

  // Management disable strap held low so control moves to management
  assign MGMT_DISABLE_STRAP = MGMT_DIS_LEVEL;

  // ------------------------------------------------------------
  // USB pull-ups and supply
  // ------------------------------------------------------------

  // Exactly one data line is pulled up, chosen by the speed level
  always_comb
  begin
    USB_CTL.dplus_pullup_en  = USB_SPEED_SELECT;
    USB_CTL.dminus_pullup_en = ~USB_SPEED_SELECT;
    USB_CTL.vbus_connect     = ~USB_POWER_ENABLE_N;
  end

  // ------------------------------------------------------------
  // Serial port handshakes
  // ------------------------------------------------------------

  // Line handshake outputs are always asserted; request to send unused
  always_comb
  begin
    SER1_MODEM.carrier_detect = MODEM_ASSERTED;
    SER1_MODEM.data_set_ready = MODEM_ASSERTED;
    SER1_MODEM.clear_to_send  = MODEM_ASSERTED;
    SER2_MODEM.carrier_detect = MODEM_ASSERTED;
    SER2_MODEM.data_set_ready = MODEM_ASSERTED;
    SER2_MODEM.clear_to_send  = MODEM_ASSERTED;
  end

  // Terminal-ready levels registered onto the TERMINAL_READY outputs
  logic [1:0] term_ready_q;
  logic [1:0] term_ready_d;

  assign term_ready_d = {SER2_TERMINAL_READY, SER1_TERMINAL_READY};

  // Terminal-ready sample register
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      term_ready_q <= 2'h0;
    else if (CE)
      term_ready_q <= term_ready_d;
  end

  assign TERMINAL_READY = term_ready_q;

endmodule // board_ctl_regs

// >>> board_ctl_regs_asserts.sv
// Port-level checker for the board control register bank
`timescale 1ns/1ns
module board_ctl_regs_chk
  import board_ctl_pkg::*;
(
  input wire logic                               CLK,
  input wire logic                               RST,
  input wire logic                               CE,
  input wire logic                               CS_N,
  input wire logic [board_ctl_pkg::IDX_W-1:0]    ADDR,
  input wire logic                               WE_N,
  input wire logic [board_ctl_pkg::DATA_W-1:0]   DATA_IN,
  input wire logic [board_ctl_pkg::DATA_W-1:0]   DATA_OUT,
  input wire logic                               DATA_OE_N,
  input wire logic                               HARD_RESET_N,
  input wire logic                               CFG_SOURCE_JUMPER,
  input wire logic                               USER_LED_TWO,
  input wire board_ctl_pkg::module_enables_t     MODULE_ENABLES_N,
  input wire board_ctl_pkg::module_enables_t     EXP_ENABLES_N,
  input wire logic                               CELL_PHY_RESET_N,
  input wire board_ctl_pkg::modem_out_t          SER1_MODEM
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Decoded access kinds
  wire rd_take = CE && !CS_N && WE_N;
  wire wr_take = CE && !CS_N && !WE_N;

  // Read answer timing and content
  a_read_oe_next: assert property (rd_take |=> !DATA_OE_N) else $error("no bus drive after read");
  a_oe_needs_read: assert property (!DATA_OE_N && $past(CE) |-> $past(rd_take)) else $error("bus drive without read");
  a_lanes_zero: assert property (DATA_OUT[23:0] == 24'h0) else $error("low lanes not zero");
  a_jumper_shown: assert property (rd_take && ADDR == 3'h1 |=> DATA_OUT[31] == $past(CFG_SOURCE_JUMPER))
    else $error("jumper bit wrong");
  a_hole_zero: assert property (rd_take && ADDR > 3'h1 |=> DATA_OUT[31:24] == 8'h0)
    else $error("hole index not zero");
  // Control outputs
  a_led_write: assert property (wr_take && ADDR == 3'h0 |=> USER_LED_TWO == $past(DATA_IN[24]))
    else $error("led two not written");
  a_cell_hard: assert property (!HARD_RESET_N |-> !CELL_PHY_RESET_N) else $error("cell reset not forced");
  a_exp_mirror: assert property (EXP_ENABLES_N == MODULE_ENABLES_N) else $error("expansion copy differs");
  a_modem_held: assert property (SER1_MODEM == 3'b111) else $error("modem line not asserted");
endmodule // board_ctl_regs_chk

bind board_ctl_regs board_ctl_regs_chk u_chk (.CLK(CLK), .RST(RST), .CE(CE), .CS_N(CS_N), .ADDR(ADDR),
  .WE_N(WE_N), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .HARD_RESET_N(HARD_RESET_N),
  .CFG_SOURCE_JUMPER(CFG_SOURCE_JUMPER), .USER_LED_TWO(USER_LED_TWO), .MODULE_ENABLES_N(MODULE_ENABLES_N),
  .EXP_ENABLES_N(EXP_ENABLES_N), .CELL_PHY_RESET_N(CELL_PHY_RESET_N), .SER1_MODEM(SER1_MODEM));

// >>> host_bus_model.sv
// Host memory-controller chip-select master model
`timescale 1ns/1ns
module host_bus_model (
  input  wire logic        CLK,
  output logic             CS_N,
  output logic [2:0]       ADDR,
  output logic             WE_N,
  output logic [31:0]      DATA_IN,
  input  wire logic [31:0] DATA_OUT,
  input  wire logic        DATA_OE_N
);
  // Idle bus at time zero
  initial
  begin
    CS_N = 1'b1;
    WE_N = 1'b1;
    ADDR = 3'h0;
    DATA_IN = 32'h5a5a5a5a;
  end
  // Deselect; released lines show the inverse of their last value
  task idle;
    CS_N <= 1'b1;
    WE_N <= 1'b1;
    ADDR <= ~ADDR;
    DATA_IN <= ~DATA_IN;
    @(posedge CLK);
  endtask
  // One write, taken at the next edge; caller sits on an edge
  task write_reg(input logic [2:0] idx, input logic [31:0] d);
    CS_N <= 1'b0;
    WE_N <= 1'b0;
    ADDR <= idx;
    DATA_IN <= d;
    @(posedge CLK);
  endtask
  // One read; answer taken one edge after the taking edge
  task read_reg(input logic [2:0] idx, output logic [31:0] d, output logic oe_n);
    CS_N <= 1'b0;
    WE_N <= 1'b1;
    ADDR <= idx;
    @(posedge CLK);
    idle();
    d = DATA_OUT;
    oe_n = DATA_OE_N;
  endtask
endmodule // host_bus_model

// >>> tb_board_ctl_regs.sv
// Self-checking testbench for the board control register bank
`timescale 1ns/1ns
module tb_board_ctl_regs;
  import board_ctl_pkg::*;
  logic            clk, rst, ce, cs_n, we_n, hrst_n, jmp_cfg, jmp_boot, usb_speed_select, usb_pwr_n, tr1, tr2;
  logic [2:0]      addr;
  logic [31:0]     din, dout, rd;
  logic            oe_n, oe, led1, led2, cell_rst_n, eth_ien_n, eth_rst_n, mgmt;
  logic [5:0]      w;
  logic [1:0]      trdy;
  module_enables_t en_n, exp_n;
  usb_ctl_t        usb;
  modem_out_t      m1, m2;
  int              fail_count, total_checks, cyc, i;
  // Control outputs in bit order 2..7
  wire [5:0] obs = {en_n.cell_phy_enable_n, cell_rst_n, eth_ien_n, eth_rst_n,
                    en_n.serial1_xcvr_enable_n, en_n.serial2_xcvr_enable_n};

  board_ctl_regs dut (.CLK(clk), .RST(rst), .CE(ce), .CS_N(cs_n), .ADDR(addr), .WE_N(we_n), .DATA_IN(din),
    .DATA_OUT(dout), .DATA_OE_N(oe_n), .HARD_RESET_N(hrst_n), .CFG_SOURCE_JUMPER(jmp_cfg),
    .BOOT_SELECT_FLASH(jmp_boot), .USB_SPEED_SELECT(usb_speed_select), .USB_POWER_ENABLE_N(usb_pwr_n),
    .SER1_TERMINAL_READY(tr1), .SER2_TERMINAL_READY(tr2), .USER_LED_ONE(led1), .USER_LED_TWO(led2),
    .MODULE_ENABLES_N(en_n), .EXP_ENABLES_N(exp_n), .CELL_PHY_RESET_N(cell_rst_n),
    .ETH1_INITIAL_ENABLE_N(eth_ien_n), .ETH1_PHY_RESET_N(eth_rst_n), .MGMT_DISABLE_STRAP(mgmt),
    .USB_CTL(usb), .SER1_MODEM(m1), .SER2_MODEM(m2), .TERMINAL_READY(trdy));
  host_bus_model host (.CLK(clk), .CS_N(cs_n), .ADDR(addr), .WE_N(we_n), .DATA_IN(din),
    .DATA_OUT(dout), .DATA_OE_N(oe_n));

  // Clock, 20 ns period
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task rd_chk(input logic [2:0] idx, input logic [31:0] exp);
    host.read_reg(idx, rd, oe);
    chk(rd, exp);
    chk(32'(oe), 32'h0);
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  initial
  begin
    rst = 1'b1; ce = 1'b1; hrst_n = 1'b1; jmp_cfg = 1'b1; jmp_boot = 1'b0;
    usb_speed_select = 1'b0; usb_pwr_n = 1'b1; tr1 = 1'b0; tr2 = 1'b0;
    fail_count = 0; total_checks = 0; cyc = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Power-on defaults
    chk(32'(obs), 32'h3f);
    chk(32'({led1, led2}), 32'h0);
    chk(32'(mgmt), 32'h0);
    rd_chk(3'h0, 32'h0);
    rd_chk(3'h1, 32'hbf000000);
    // LED write with junk in the unused lanes
    host.write_reg(3'h0, 32'h01ffffff);
    host.idle();
    chk(32'({led1, led2}), 32'h1);
    rd_chk(3'h0, 32'h01000000);
    // Walk one low bit over bits 2..7, jumper bits written as ones
    for (i = 0; i < 6; i++)
    begin
      w = 6'h3f ^ (6'h20 >> i);
      host.write_reg(3'h1, {2'b11, w, 24'hffffff});
      host.idle();
      chk(32'(obs), 32'(w));
    end
    chk(32'(exp_n), 32'h6);
    rd_chk(3'h1, 32'hbe000000);
    // Jumpers swapped
    jmp_cfg <= 1'b0;
    jmp_boot <= 1'b1;
    host.idle();
    rd_chk(3'h1, 32'h7e000000);
    // Hard reset forces only the PHY resets
    hrst_n <= 1'b0;
    host.idle();
    chk(32'({cell_rst_n, eth_rst_n, eth_ien_n}), 32'h1);
    hrst_n <= 1'b1;
    host.idle();
    rd_chk(3'h1, 32'h7e000000);
    // Back-to-back writes to both registers
    host.write_reg(3'h0, 32'h02000000);
    host.write_reg(3'h1, 32'h0);
    host.idle();
    chk(32'({led1, led2}), 32'h2);
    chk(32'(obs), 32'h0);
    // Unimplemented indexes read zero and do not alias
    for (i = 2; i < 8; i++)
    begin
      host.write_reg(3'(i), 32'hffffffff);
      rd_chk(3'(i), 32'h0);
    end
    rd_chk(3'h0, 32'h02000000);
    // Clock enable low blocks a write
    ce <= 1'b0;
    host.write_reg(3'h0, 32'hff000000);
    ce <= 1'b1;
    host.idle();
    chk(32'({led1, led2}), 32'h2);
    // USB pull-ups, supply, modem lines and terminal ready
    usb_speed_select <= 1'b1;
    usb_pwr_n <= 1'b0;
    tr1 <= 1'b1;
    host.idle();
    host.idle();
    chk(32'(usb), 32'h5);
    chk(32'({m1, m2}), 32'h3f);
    chk(32'(trdy), 32'h1);
    usb_speed_select <= 1'b0;
    usb_pwr_n <= 1'b1;
    tr1 <= 1'b0;
    tr2 <= 1'b1;
    host.idle();
    chk(32'(usb), 32'h2);
    host.idle();
    chk(32'(trdy), 32'h2);
    // Power-on reset mid-run restores the defaults
    rst <= 1'b1;
    host.idle();
    rst <= 1'b0;
    host.idle();
    chk(32'(obs), 32'h3f);
    chk(32'({led1, led2}), 32'h0);
    rd_chk(3'h0, 32'h0);
    rd_chk(3'h1, 32'h7f000000);
    give_verdict();
  end
endmodule // tb_board_ctl_regs
